// ==== pft_core.sv ====
// pixel stage: format packing, sample alignment, test patterns and mirroring
`timescale 1ns/1ps
`default_nettype none
module pft_core
  import pft_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic in_sof,
  input wire logic [pft_pkg::RAW_W-1:0] in_raw,
  input wire logic [7:0] in_r,
  input wire logic [7:0] in_g,
  input wire logic [7:0] in_b,
  input wire pft_pkg::pft_adc_t adc_depth,
  input wire pft_pkg::pft_fmt_t out_format,
  input wire logic acq_start,
  input wire logic cfg_write,
  input wire pft_pkg::pft_gen_t test_generator_choice,
  input wire pft_pkg::pft_pat_t pattern_kind_control,
  input wire logic mirror_h,
  input wire logic mirror_v,
  input wire pft_pkg::pft_bayer_t bayer_in,
  output pft_pkg::pft_bayer_t bayer_out,
  output logic sensor_pattern_on,
  output pft_pkg::pft_pat_t pipe_pattern_kind,
  output logic real_image,
  output logic out_valid,
  input wire logic out_ready,
  output logic [pft_pkg::OUT_W-1:0] out_data,
  output logic out_sof,
  output logic out_eol
);

  typedef enum logic [1:0] {
    ST_FILL = 2'b01,
    ST_DRAIN = 2'b10
  } pft_state_t;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // generator configuration
  // ---------------------------------------------------------------
  logic sens_on_q;
  pft_pat_t pipe_kind_q;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sens_on_q <= 1'b0;
      pipe_kind_q <= PAT_OFF;
    end
    else if (cfg_write)
    begin
      // a kind the chosen generator cannot make is ignored
      if (test_generator_choice == GEN_SENSOR)
      begin
        if (pattern_kind_control == PAT_OFF || pattern_kind_control == PAT_SENSOR)
          sens_on_q <= (pattern_kind_control == PAT_SENSOR);
      end
      else if (pattern_kind_control != PAT_SENSOR)
        pipe_kind_q <= pattern_kind_control;
    end
  end

  assign sensor_pattern_on = sens_on_q;
  assign pipe_pattern_kind = pipe_kind_q;
  assign real_image = !sens_on_q && (pipe_kind_q == PAT_OFF);

  // ---------------------------------------------------------------
  // input side: source choice and frame store write
  // ---------------------------------------------------------------
  pft_state_t state_q;
  logic [X_W-1:0] wx_q;
  logic [Y_W-1:0] wy_q;
  logic [X_W-1:0] wx;
  logic [Y_W-1:0] wy;
  logic [7:0] ramp_q;
  logic [7:0] ramp_now;
  logic [3:0] frame_q;
  logic [7:0] pipe_val;
  logic [7:0] sens_val;
  logic [7:0] pat_val;
  logic [15:0] raw16;
  logic [WORD_W-1:0] wr_word;
  logic acc;
  logic last_wr;
  logic [WORD_W-1:0] mem [PIX_N];

  assign in_ready = (state_q == ST_FILL);
  assign acc = in_valid && in_ready;
  // frame start resynchronises the write position
  assign wx = in_sof ? '0 : wx_q;
  assign wy = in_sof ? '0 : wy_q;
  assign last_wr = (wx == X_LAST) && (wy == Y_LAST);
  assign ramp_now = in_sof ? RAMP_RST : ramp_q;
  assign pipe_val = (pipe_kind_q == PAT_VARSEQ) ? ramp_now + {frame_q, 4'h0} : ramp_now;
  assign sens_val = {wx, 1'b0, wy};

  always_comb
  begin
    unique case (adc_depth)
      ADC_10: raw16 = {in_raw[9:0], 6'h00};
      ADC_12: raw16 = {in_raw[11:0], 4'h0};
      default: raw16 = {in_raw[13:0], 2'h0};
    endcase
  end

  // pattern pixels enter before conversion, so later stages still act on them
  always_comb
  begin
    pat_val = sens_val;
    if (pipe_kind_q != PAT_OFF)
      pat_val = pipe_val;
    if (real_image)
      wr_word = {raw16, in_r, in_g, in_b};
    else
      wr_word = {pat_val, 8'h00, pat_val, pat_val, pat_val};
  end

  always_ff @(posedge core_clk)
  begin
    if (acc)
      mem[{wy, wx}] <= wr_word;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      ramp_q <= RAMP_RST;
    else if (acc)
      ramp_q <= ramp_now + RAMP_STEP;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst || acq_start)
      frame_q <= FRAME_RST;
    else if (acc && last_wr)
      frame_q <= frame_q + 4'h1;
  end

  // ---------------------------------------------------------------
  // store sequencing and mirrored read order
  // ---------------------------------------------------------------
  logic [X_W-1:0] rx_q;
  logic [Y_W-1:0] ry_q;
  logic hflip_q;
  logic vflip_q;
  logic pend_q;
  logic buf_in_ready;
  logic issue;
  logic last_rd;
  logic [ADDR_W-1:0] rd_addr;
  logic [WORD_W-1:0] mem_q;
  logic sof_pend_q;
  logic eol_pend_q;
  logic [1:0] xph_q;

  assign issue = (state_q == ST_DRAIN) && (!pend_q || buf_in_ready);
  assign last_rd = (rx_q == X_LAST) && (ry_q == Y_LAST);
  // power-of-two geometry makes the reversed index a plain inversion
  assign rd_addr = {vflip_q ? ~ry_q : ry_q, hflip_q ? ~rx_q : rx_q};

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q <= ST_FILL;
      wx_q <= '0;
      wy_q <= '0;
      rx_q <= '0;
      ry_q <= '0;
      hflip_q <= 1'b0;
      vflip_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ST_FILL:
        begin
          if (acc)
          begin
            wx_q <= wx + 4'h1;
            if (wx == X_LAST)
              wy_q <= wy + 3'h1;
            else
              wy_q <= wy;
            if (last_wr)
            begin
              // flips are frozen per frame so a change never tears an image
              state_q <= ST_DRAIN;
              hflip_q <= mirror_h;
              vflip_q <= mirror_v;
              rx_q <= '0;
              ry_q <= '0;
            end
          end
        end
        ST_DRAIN:
        begin
          if (issue)
          begin
            rx_q <= rx_q + 4'h1;
            if (rx_q == X_LAST)
              ry_q <= ry_q + 3'h1;
            if (last_rd)
              state_q <= ST_FILL;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (issue)
    begin
      mem_q <= mem[rd_addr];
      sof_pend_q <= (rx_q == '0) && (ry_q == '0);
      eol_pend_q <= (rx_q == X_LAST);
      xph_q <= rx_q[1:0];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      pend_q <= 1'b0;
    else if (issue)
      pend_q <= 1'b1;
    else if (buf_in_ready)
      pend_q <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      bayer_out <= BAYER_RG;
    else
      bayer_out <= pft_bayer_t'(bayer_in ^ {vflip_q, hflip_q});
  end

  // ---------------------------------------------------------------
  // colour conversion and packing
  // ---------------------------------------------------------------
  logic [7:0] px_r;
  logic [7:0] px_g;
  logic [7:0] px_b;
  logic [15:0] y_acc;
  logic [7:0] y_c;
  logic [7:0] cb_c;
  logic [7:0] cr_c;
  logic [7:0] cr_hold_q;
  logic [7:0] chroma;
  logic [OUT_W-1:0] pack;
  logic push;

  function automatic logic [7:0] chroma_of(input logic signed [17:0] kr, input logic signed [17:0] kg,
                                           input logic signed [17:0] kb, input logic [7:0] r,
                                           input logic [7:0] g, input logic [7:0] b);
    logic signed [35:0] sum;
    logic signed [35:0] sh;
    sum = kr * $signed({10'h000, r}) + kg * $signed({10'h000, g}) + kb * $signed({10'h000, b}) + CHROMA_OFS;
    sh = sum >>> FRAC_SH;
    if (sh < 36'sd0)
      return 8'h00;
    else if (sh > 36'sd255)
      return 8'hFF;
    return sh[7:0];
  endfunction

  assign px_r = mem_q[23:16];
  assign px_g = mem_q[15:8];
  assign px_b = mem_q[7:0];
  // weights sum to 256, so white stays at 255 without saturation
  assign y_acc = Y_KR * {8'h00, px_r} + Y_KG * {8'h00, px_g} + Y_KB * {8'h00, px_b};
  assign y_c = y_acc[15:8];
  assign cb_c = chroma_of(CB_KR, CB_KG, CB_KB, px_r, px_g, px_b);
  assign cr_c = chroma_of(CR_KR, CR_KG, CR_KB, px_r, px_g, px_b);
  assign push = pend_q && buf_in_ready;

  // red-difference chroma of the group's first pixel rides on the next one
  always_ff @(posedge core_clk)
  begin
    if (push && !xph_q[0])
      cr_hold_q <= cr_c;
  end

  always_comb
  begin
    chroma = 8'h00;
    pack = {y_c, cb_c, cr_c};
    unique case (out_format)
      FMT_RAW8:
        pack = {16'h0000, mem_q[39:32]};
      FMT_RAW16:
        pack = {8'h00, mem_q[39:24]};
      FMT_YUV422:
      begin
        chroma = xph_q[0] ? cr_hold_q : cb_c;
        pack = {y_c, chroma, 8'h00};
      end
      FMT_YUV411:
      begin
        if (xph_q == 2'h0)
          chroma = cb_c;
        else if (xph_q == 2'h1)
          chroma = cr_hold_q;
        pack = {y_c, chroma, 8'h00};
      end
      default:
        pack = {y_c, cb_c, cr_c};
    endcase
  end

  pft_buf2 u_buf (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(pend_q),
    .in_ready(buf_in_ready),
    .in_data({sof_pend_q, eol_pend_q, pack}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data({out_sof, out_eol, out_data})
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_ramp_step:
    assert property ((acc && pipe_kind_q == PAT_RAMP && !in_sof) |=> ramp_q == $past(ramp_q) + 8'h01)
    else $error("ramp did not advance by one");
  a_pipe_wins_sensor:
    assert property ((acc && pipe_kind_q != PAT_OFF && sens_on_q) |-> wr_word[7:0] == pipe_val)
    else $error("pipeline pattern did not replace sensor pattern");
  a_real_only_off:
    assert property ((acc && (sens_on_q || pipe_kind_q != PAT_OFF)) |-> wr_word[31:24] == 8'h00
                     && wr_word[23:16] == wr_word[7:0])
    else $error("sensor data passed while a generator was on");
  a_off_keeps_other:
    assert property ((cfg_write && test_generator_choice == GEN_SENSOR) |=> pipe_kind_q == $past(pipe_kind_q))
    else $error("sensor write changed pipeline generator");
  a_sensor_kind_only:
    assert property ((cfg_write && test_generator_choice == GEN_SENSOR && pattern_kind_control == PAT_RAMP)
                     |=> sens_on_q == $past(sens_on_q))
    else $error("sensor generator took an illegal kind");
  a_series_restart:
    assert property (acq_start |=> frame_q == 4'h0)
    else $error("frame series not restarted");
  a_pad_twelve:
    assert property ((acc && real_image && adc_depth == ADC_12 && in_raw[11:0] == 12'hFFF)
                     |-> wr_word[39:24] == 16'hFFF0)
    else $error("12-bit full scale not left aligned");
  a_hflip_order:
    assert property ((issue && hflip_q && rx_q == '0) |-> rd_addr[X_W-1:0] == X_LAST)
    else $error("mirrored line does not start at far column");
  a_bayer_col:
    assert property ((hflip_q && !vflip_q && bayer_in == BAYER_RG) |=> bayer_out == BAYER_GR)
    else $error("column phase not swapped");
  a_bayer_row:
    assert property ((vflip_q && !hflip_q && bayer_in == BAYER_RG) |=> bayer_out == BAYER_GB)
    else $error("row phase not swapped");
  a_raw8_trunc:
    assert property ((push && out_format == FMT_RAW8) |-> pack[23:8] == 16'h0000 && pack[7:0] == mem_q[39:32])
    else $error("raw word not cut to its top byte");
  a_chroma_411:
    assert property ((push && out_format == FMT_YUV411 && xph_q[1]) |-> pack[15:0] == 16'h0000)
    else $error("4:1:1 carried chroma on a skipped pixel");
  a_chroma_422:
    assert property ((push && out_format == FMT_YUV422 && xph_q[0]) |-> pack[15:8] == cr_hold_q)
    else $error("4:2:2 odd pixel did not carry held chroma");
  a_luma_lane:
    assert property ((push && out_format == FMT_YUV444 && px_r == px_g && px_g == px_b) |-> pack == {px_r, 16'h8080})
    else $error("grey pixel did not give equal luma and mid chroma");

  c_both_flips: cover property (issue && last_rd && hflip_q && vflip_q);
  c_series_frame: cover property (acc && pipe_kind_q == PAT_VARSEQ && last_wr);
  c_fmt_411: cover property (push && out_format == FMT_YUV411 && xph_q == 2'h3);
  c_stall: cover property (pend_q && !buf_in_ready);

endmodule
`default_nettype wire

// ==== pft_pkg.sv ====
// shared constants and types for the pixel format / test pattern / flip stage
package pft_pkg;

  // ---------------------------------------------------------------
  // frame geometry held in the frame store
  // ---------------------------------------------------------------
  localparam int IMG_W = 16;
  localparam int IMG_H = 8;
  localparam int X_W = 4;
  localparam int Y_W = 3;
  localparam int ADDR_W = X_W + Y_W;
  localparam int PIX_N = IMG_W * IMG_H;
  localparam logic [X_W-1:0] X_LAST = 4'hF;
  localparam logic [Y_W-1:0] Y_LAST = 3'h7;

  // ---------------------------------------------------------------
  // word layouts
  // ---------------------------------------------------------------
  localparam int RAW_W = 14;
  localparam int WORD_W = 40;
  localparam int OUT_W = 24;
  localparam int BUF_W = OUT_W + 2;
  localparam int BUF_DEPTH = 2;

  // ---------------------------------------------------------------
  // luma/chroma coefficients, scaled by 256
  // ---------------------------------------------------------------
  localparam int FRAC_SH = 8;
  localparam logic [15:0] Y_KR = 16'h004D;
  localparam logic [15:0] Y_KG = 16'h0096;
  localparam logic [15:0] Y_KB = 16'h001D;
  localparam logic signed [17:0] CB_KR = -18'sd43;
  localparam logic signed [17:0] CB_KG = -18'sd85;
  localparam logic signed [17:0] CB_KB = 18'sd128;
  localparam logic signed [17:0] CR_KR = 18'sd128;
  localparam logic signed [17:0] CR_KG = -18'sd107;
  localparam logic signed [17:0] CR_KB = -18'sd21;
  localparam logic signed [35:0] CHROMA_OFS = 36'sd32768;

  // ---------------------------------------------------------------
  // pattern constants and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RAMP_STEP = 8'h01;
  localparam logic [7:0] RAMP_RST = 8'h00;
  localparam logic [3:0] FRAME_RST = 4'h0;
  localparam logic [1:0] BAYER_RST = 2'h0;

  typedef enum logic [2:0] {
    FMT_RAW8 = 3'h0,
    FMT_RAW16 = 3'h1,
    FMT_YUV444 = 3'h2,
    FMT_YUV422 = 3'h3,
    FMT_YUV411 = 3'h4
  } pft_fmt_t;

  typedef enum logic [1:0] {
    ADC_10 = 2'h0,
    ADC_12 = 2'h1,
    ADC_14 = 2'h2
  } pft_adc_t;

  typedef enum logic {
    GEN_SENSOR = 1'b0,
    GEN_PIPE = 1'b1
  } pft_gen_t;

  typedef enum logic [1:0] {
    PAT_OFF = 2'h0,
    PAT_SENSOR = 2'h1,
    PAT_RAMP = 2'h2,
    PAT_VARSEQ = 2'h3
  } pft_pat_t;

  // bit 0 column phase, bit 1 row phase
  typedef enum logic [1:0] {
    BAYER_RG = 2'h0,
    BAYER_GR = 2'h1,
    BAYER_GB = 2'h2,
    BAYER_BG = 2'h3
  } pft_bayer_t;

endpackage

// ==== pft_buf2.sv ====
// two-entry valid/ready buffer in front of the output port
`timescale 1ns/1ps
`default_nettype none
module pft_buf2
  import pft_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [pft_pkg::BUF_W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [pft_pkg::BUF_W-1:0] out_data
);

  logic [1:0] cnt_q;
  logic [BUF_W-1:0] d1_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != 2'(BUF_DEPTH));
  assign out_valid = (cnt_q != 2'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      cnt_q <= 2'h0;
    else if (push && !pop)
      cnt_q <= cnt_q + 2'h1;
    else if (pop && !push)
      cnt_q <= cnt_q - 2'h1;
  end

  // head stays put until popped, so a stalled receiver loses nothing
  always_ff @(posedge core_clk)
  begin
    unique case ({push, pop})
      2'b10:
      begin
        if (cnt_q == 2'h0)
          out_data <= in_data;
        else
          d1_q <= in_data;
      end
      2'b01:
        out_data <= d1_q;
      2'b11:
      begin
        if (cnt_q == 2'h1)
          out_data <= in_data;
        else
        begin
          out_data <= d1_q;
          d1_q <= in_data;
        end
      end
      default:
      begin
      end
    endcase
  end

  a_buf_no_overflow: assert property (@(posedge core_clk) disable iff (rst)
    (cnt_q == 2'h2 && !out_ready) |=> (cnt_q == 2'h2 && out_data == $past(out_data)))
    else $error("buffer lost or changed its head while full and stalled");

endmodule
`default_nettype wire

// ==== pft_strm_model.sv ====
// pixel source upstream and stalling sink downstream of the pixel stage
`timescale 1ns/1ps
`default_nettype none
module pft_strm_model
  import pft_pkg::*;
(
  input wire logic core_clk,
  input wire logic start,
  input wire logic stall,
  input wire logic [pft_pkg::RAW_W-1:0] raw_mask,
  input wire logic in_ready,
  output logic in_valid,
  output logic in_sof,
  output logic [37:0] pixel,
  output logic out_ready
);
  logic busy = 1'b0;
  logic [37:0] last = '0;
  int n = 0;
  int tick = 0;
  // {raw, r, g, b} of pixel i; pixel 0 has a full-scale raw sample
  function automatic logic [37:0] pix(input int i);
    logic [6:0] v;
    v = 7'(i);
    return {(i == 0) ? 14'h3FFF : {v, ~v}, v, 1'b0, 8'hFF - {1'b0, v}, {v, 1'b0} ^ 8'h5A};
  endfunction
  initial
  begin
    in_valid = 1'b0;
    in_sof = 1'b0;
    pixel = '0;
    out_ready = 1'b1;
  end
  always @(posedge core_clk)
  begin
    if (start)
    begin
      busy <= 1'b1;
      n <= 0;
    end
    else if (in_valid && in_ready)
    begin
      n <= n + 1;
      busy <= n < 127;
    end
  end
  // idle data lines show the inverse, never a stale copy
  always @(negedge core_clk)
  begin
    tick <= tick + 1;
    out_ready <= !stall || tick % 3 == 0;
    in_valid <= busy;
    in_sof <= busy && n == 0;
    if (busy)
    begin
      pixel <= pix(n) & {raw_mask, 24'hFFFFFF};
      last <= pix(n) & {raw_mask, 24'hFFFFFF};
    end
    else
      pixel <= ~last;
  end
endmodule
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the pixel stage
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pft_pkg::*;
  logic core_clk, rst, start, stall, cfg_write, acq_start, mirror_h, mirror_v;
  logic in_valid, in_ready, in_sof, out_valid, out_ready, out_sof, out_eol, sensor_pattern_on, real_image;
  logic [37:0] pixel;
  logic [RAW_W-1:0] raw_mask;
  logic [OUT_W-1:0] out_data, w1, first;
  logic [23:0] wmask;
  pft_adc_t adc_depth;
  pft_fmt_t out_format;
  pft_gen_t test_generator_choice;
  pft_pat_t pattern_kind_control, pipe_pattern_kind;
  pft_bayer_t bayer_in, bayer_out;
  pft_fmt_t fl[3] = '{FMT_YUV444, FMT_YUV422, FMT_YUV411};
  int bad_count = 0;
  int n_checks = 0;
  int k = 0;
  int mode = 0;
  assign wmask = out_format == FMT_RAW8 ? 24'h0000FF : out_format == FMT_RAW16 ? 24'h00FFFF : 24'hFFFFFF;
  pft_core DUT (.core_clk(core_clk), .rst(rst), .in_valid(in_valid), .in_ready(in_ready), .in_sof(in_sof),
    .in_raw(pixel[37:24]), .in_r(pixel[23:16]), .in_g(pixel[15:8]), .in_b(pixel[7:0]), .adc_depth(adc_depth),
    .out_format(out_format), .acq_start(acq_start), .cfg_write(cfg_write),
    .test_generator_choice(test_generator_choice), .pattern_kind_control(pattern_kind_control),
    .mirror_h(mirror_h), .mirror_v(mirror_v), .bayer_in(bayer_in), .bayer_out(bayer_out),
    .sensor_pattern_on(sensor_pattern_on), .pipe_pattern_kind(pipe_pattern_kind), .real_image(real_image),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_sof(out_sof), .out_eol(out_eol));
  pft_strm_model mdl (.core_clk(core_clk), .start(start), .stall(stall), .raw_mask(raw_mask),
    .in_ready(in_ready), .in_valid(in_valid), .in_sof(in_sof), .pixel(pixel), .out_ready(out_ready));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ----
  // checking helpers
  // ----
  task automatic chk(input string s, input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  function automatic int src_of(input int kk);
    int r, c;
    r = kk / IMG_W;
    c = kk % IMG_W;
    return (mirror_v ? IMG_H - 1 - r : r) * IMG_W + (mirror_h ? IMG_W - 1 - c : c);
  endfunction
  function automatic logic [23:0] yuv_at(input int s);
    logic [37:0] p;
    int r, g, b, y, cb, cr;
    p = mdl.pix(s);
    r = int'(p[23:16]);
    g = int'(p[15:8]);
    b = int'(p[7:0]);
    y = (int'(Y_KR) * r + int'(Y_KG) * g + int'(Y_KB) * b) >>> FRAC_SH;
    cb = (int'(CB_KR) * r + int'(CB_KG) * g + int'(CB_KB) * b + 32768) >>> FRAC_SH;
    cr = (int'(CR_KR) * r + int'(CR_KG) * g + int'(CR_KB) * b + 32768) >>> FRAC_SH;
    cb = cb < 0 ? 0 : cb > 255 ? 255 : cb;
    cr = cr < 0 ? 0 : cr > 255 ? 255 : cr;
    return {8'(y), 8'(cb), 8'(cr)};
  endfunction
  // expected word k of a frame, in mirrored output order
  function automatic logic [23:0] exp_word(input int kk);
    int s, c, w;
    logic [7:0] v;
    logic [15:0] a;
    logic [23:0] cur, prv;
    s = src_of(kk);
    c = kk % IMG_W;
    w = adc_depth == ADC_10 ? 10 : adc_depth == ADC_12 ? 12 : 14;
    v = mode == 1 ? 8'(s) : {4'(s % IMG_W), 1'b0, 3'(s / IMG_W)};
    a = mode == 0 ? 16'((mdl.pix(s) >> 24) & 38'(raw_mask)) << (16 - w) : {v, 8'h00};
    // pattern pixels are grey, so chroma sits at its midpoint
    cur = mode == 0 ? yuv_at(s) : {v, 16'h8080};
    prv = mode == 0 ? yuv_at(src_of(c > 0 ? kk - 1 : kk)) : 24'h008080;
    case (out_format)
      FMT_RAW8: return {16'h0000, a[15:8]};
      FMT_RAW16: return {8'h00, a};
      FMT_YUV444: return cur;
      FMT_YUV422: return {cur[23:16], c % 2 == 0 ? cur[15:8] : prv[7:0], 8'h00};
      default: return {cur[23:16], c % 4 == 0 ? cur[15:8] : c % 4 == 1 ? prv[7:0] : 8'h00, 8'h00};
    endcase
  endfunction
  always @(posedge core_clk)
  begin
    if (!rst && out_valid && out_ready)
    begin
      if (mode == 3)
      begin
        if (k == 1)
          w1 <= out_data;
      end
      else
        chk("out_data", exp_word(k) & wmask, out_data & wmask);
      chk("out_sof", 24'(k == 0), 24'(out_sof));
      chk("out_eol", 24'(k % 16 == 15), 24'(out_eol));
      k <= k + 1;
    end
  end
  task automatic frame();
    int t;
    @(negedge core_clk);
    k = 0;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    t = 0;
    while (k < PIX_N && t < 2000)
    begin
      @(negedge core_clk);
      t++;
    end
    chk("frame words", 24'(PIX_N), 24'(k));
  endtask
  task automatic cfg(input pft_gen_t g, input pft_pat_t p);
    @(negedge core_clk);
    test_generator_choice = g;
    pattern_kind_control = p;
    cfg_write = 1'b1;
    @(negedge core_clk);
    cfg_write = 1'b0;
  endtask
  task automatic acq();
    @(negedge core_clk);
    acq_start = 1'b1;
    @(negedge core_clk);
    acq_start = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial
  begin
    rst = 1'b1;
    start = 1'b0;
    stall = 1'b0;
    cfg_write = 1'b0;
    acq_start = 1'b0;
    mirror_h = 1'b0;
    mirror_v = 1'b0;
    raw_mask = 14'h0FFF;
    adc_depth = ADC_12;
    out_format = FMT_RAW16;
    test_generator_choice = GEN_SENSOR;
    pattern_kind_control = PAT_OFF;
    bayer_in = BAYER_RG;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    chk("real_image", 24'h1, 24'(real_image));
    chk("pipe_pattern_kind", 24'(PAT_OFF), 24'(pipe_pattern_kind));
    chk("bayer_out", 24'(BAYER_RG), 24'(bayer_out));
    $display("done reset");
    frame();
    // resolution only changes between frames, with the source idle
    adc_depth = ADC_14;
    raw_mask = 14'h3FFF;
    out_format = FMT_RAW8;
    frame();
    adc_depth = ADC_10;
    raw_mask = 14'h03FF;
    out_format = FMT_RAW16;
    stall = 1'b1;
    frame();
    adc_depth = ADC_12;
    raw_mask = 14'h0FFF;
    for (int i = 0; i < 3; i++)
    begin
      out_format = fl[i];
      frame();
    end
    stall = 1'b0;
    $display("done formats");
    out_format = FMT_RAW16;
    mirror_h = 1'b1;
    frame();
    chk("bayer_out", 24'(BAYER_GR), 24'(bayer_out));
    mirror_h = 1'b0;
    mirror_v = 1'b1;
    frame();
    chk("bayer_out", 24'(BAYER_GB), 24'(bayer_out));
    mirror_h = 1'b1;
    bayer_in = BAYER_GR;
    frame();
    chk("bayer_out", 24'(BAYER_GB), 24'(bayer_out));
    mirror_v = 1'b0;
    $display("done mirror");
    // no automatic exposure or gain loop runs while a pattern is on
    cfg(GEN_SENSOR, PAT_SENSOR);
    chk("sensor_pattern_on", 24'h1, 24'(sensor_pattern_on));
    mode = 2;
    out_format = FMT_YUV444;
    frame();
    out_format = FMT_RAW16;
    cfg(GEN_SENSOR, PAT_RAMP);
    cfg(GEN_PIPE, PAT_SENSOR);
    chk("pipe_pattern_kind", 24'(PAT_OFF), 24'(pipe_pattern_kind));
    chk("sensor_pattern_on", 24'h1, 24'(sensor_pattern_on));
    cfg(GEN_PIPE, PAT_RAMP);
    chk("pipe_pattern_kind", 24'(PAT_RAMP), 24'(pipe_pattern_kind));
    mode = 1;
    frame();
    cfg(GEN_PIPE, PAT_OFF);
    chk("sensor_pattern_on", 24'h1, 24'(sensor_pattern_on));
    chk("real_image", 24'h0, 24'(real_image));
    cfg(GEN_SENSOR, PAT_OFF);
    chk("real_image", 24'h1, 24'(real_image));
    mode = 0;
    mirror_h = 1'b0;
    frame();
    $display("done generators");
    cfg(GEN_PIPE, PAT_VARSEQ);
    mode = 3;
    acq();
    frame();
    first = w1;
    frame();
    chk("series change", 24'h1, 24'(w1 != first));
    acq();
    frame();
    chk("series restart", first, w1);
    $display("done series");
    report_and_stop();
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    $display("wrong value watchdog expected end seen timeout");
    report_and_stop();
  end
endmodule
`default_nettype wire
